// >>> fpmc_cfg.svh
`ifndef FPMC_CFG_SVH
`define FPMC_CFG_SVH
// Register offsets
`define FPMC_OFS_FLASH_CS 8'h2f
`define FPMC_OFS_EE_CS 8'h30
`define FPMC_OFS_STATUS 8'h3d
`define FPMC_OFS_RXCNT 8'h3e
`define FPMC_OFS_ERASE 8'h3f
`define FPMC_CS_RESET 8'h00
// Control and status field positions
`define FPMC_BIT_PGM 0
`define FPMC_BIT_LAT 1
`define FPMC_BIT_OPT 2
`define FPMC_BIT_ERASE_GO 0
`define FPMC_BIT_DENY 1
// Memory map of the programmable areas and the driver RAM
`define FPMC_FLASH_BASE 16'hf000
`define FPMC_FLASH_TOP 16'hffff
`define FPMC_EE_BASE 16'h1000
`define FPMC_EE_TOP 16'h107f
`define FPMC_OPT_LO 16'h0000
`define FPMC_OPT_HI 16'h001f
`define FPMC_S0_UNIT 13'h0100
`define FPMC_RAM_BASE 16'h0080
// Reset vectors
`define FPMC_APP_VECTOR 16'hfffe
`define FPMC_SYS_VECTOR 16'hbffe
// Timing
`define FPMC_CLK_NS 8
`define FPMC_PROG_HOLD_NS 2000
`define FPMC_ERASE_HOLD_NS 4000
`define FPMC_PROG_HOLD_CYC ((`FPMC_PROG_HOLD_NS + `FPMC_CLK_NS - 1) / `FPMC_CLK_NS)
`define FPMC_ERASE_HOLD_CYC ((`FPMC_ERASE_HOLD_NS + `FPMC_CLK_NS - 1) / `FPMC_CLK_NS)
`define FPMC_ENTRY_PULSES 35
`define FPMC_LAT_BYTES 32
`endif

// >>> fpmc_pkg.sv
package fpmc_pkg;
  typedef enum logic [1:0] {MODE_APP, MODE_ICC, MODE_SOCKET} fpmc_mode_t;
  typedef enum logic [2:0] {AREA_NONE, AREA_SEC0, AREA_SEC1, AREA_OPT, AREA_EE} fpmc_area_t;
  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE, ST_HOLD} fpmc_state_t;
endpackage

// >>> fpmc_if.sv
`timescale 1ns/1ns
interface fpmc_if;
  logic sclk_rise;
  logic sdata;
  logic rst_low;
  logic rx_en;
  logic enter_icc;
  logic enter_app;
  logic ram_wr;
  logic [15:0] ram_addr;
  logic [7:0] ram_wdata;
  logic drv_done;
  logic [7:0] rx_count;
  modport entry (input sclk_rise, input rst_low, output enter_icc, output enter_app);
  modport rx (input sclk_rise, input sdata, input rx_en, output ram_wr, output ram_addr,
              output ram_wdata, output drv_done, output rx_count);
endinterface

// >>> fpmc_entry.sv
`timescale 1ns/1ns
`include "fpmc_cfg.svh"
module fpmc_entry #(
  parameter int PULSES = `FPMC_ENTRY_PULSES
) (
  input wire logic clk,
  input wire logic rst,
  fpmc_if.entry lk
);
  logic [7:0] cnt_q;
  logic low_q;

  if (PULSES < 1 || PULSES > 254) begin : g_bad
    $error("entry pulse count out of range");
  end

  // Pulses only count while the reset pin is held low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (!lk.rst_low) begin
      cnt_q <= 8'h00;
    end else if (lk.sclk_rise && cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01; // [R7]
    end
  end

  // Decide at the release edge of the reset pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_q <= 1'b0;
      lk.enter_icc <= 1'b0;
      lk.enter_app <= 1'b0;
    end else begin
      low_q <= lk.rst_low;
      lk.enter_icc <= low_q && !lk.rst_low && cnt_q == 8'(PULSES); // [R7]
      lk.enter_app <= low_q && !lk.rst_low && cnt_q != 8'(PULSES); // [R12]
    end
  end

  AST_ENTRY_HELD: assert property (@(posedge clk) disable iff (rst)
    lk.enter_icc |-> $past(low_q) && $past(cnt_q) == 8'(PULSES)) else $error("entry without held reset"); // [R7]
endmodule

// >>> fpmc_rx.sv
`timescale 1ns/1ns
`include "fpmc_cfg.svh"
module fpmc_rx (
  input wire logic clk,
  input wire logic rst,
  fpmc_if.rx lk
);
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic [7:0] len_q;
  logic have_len_q;
  logic [7:0] byte_w;
  logic take;

  assign byte_w = {sh_q, lk.sdata};
  assign take = lk.rx_en && lk.sclk_rise && !lk.drv_done;

  // Bit assembly, most significant bit first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_q <= 3'h0;
      sh_q <= 7'h00;
    end else if (!lk.rx_en) begin
      bit_q <= 3'h0;
    end else if (take) begin
      sh_q <= byte_w[6:0];
      bit_q <= bit_q + 3'h1;
    end
  end

  // First byte is the driver length, then that many bytes go to RAM
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      len_q <= 8'h00;
      have_len_q <= 1'b0;
      lk.ram_wr <= 1'b0;
      lk.ram_addr <= `FPMC_RAM_BASE;
      lk.ram_wdata <= 8'h00;
      lk.rx_count <= 8'h00;
      lk.drv_done <= 1'b0;
    end else begin
      lk.ram_wr <= 1'b0;
      if (!lk.rx_en) begin
        have_len_q <= 1'b0;
        lk.rx_count <= 8'h00;
        lk.drv_done <= 1'b0;
      end else if (take && bit_q == 3'h7) begin
        if (!have_len_q) begin
          len_q <= byte_w;
          have_len_q <= byte_w != 8'h00;
        end else begin
          lk.ram_wr <= 1'b1; // [R9]
          lk.ram_addr <= `FPMC_RAM_BASE + 16'(lk.rx_count);
          lk.ram_wdata <= byte_w;
          lk.rx_count <= lk.rx_count + 8'h01;
          lk.drv_done <= (lk.rx_count + 8'h01) == len_q; // [R9]
        end
      end
    end
  end

  AST_RAM_STORE: assert property (@(posedge clk) disable iff (rst)
    lk.ram_wr |-> $past(take) && $past(bit_q) == 3'h7 && have_len_q) else $error("RAM write without a full byte"); // [R9]
  COV_DRV_DONE: cover property (@(posedge clk) disable iff (rst) $rose(lk.drv_done));
endmodule

// >>> fpmc_top.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`include "fpmc_cfg.svh"
// Behaviour
// (R1) Flash takes one byte or up to 32 latched bytes programmed in one cycle.
// (R2) Erasing or programming one sector leaves every other sector untouched.
// (R3) In a programming socket sectors 0 and 1, option row and EEPROM may be altered.
// (R4) In in-circuit mode sectors 0 and 1, option row and EEPROM may be altered on board.
// (R5) In self-programming mode only sector 1 and EEPROM may be altered.
// (R6) The sector 0 size comes from the option byte setting.
// (R7) In-circuit mode is entered by a pulse sequence on the serial pins under held reset.
// (R8) Entering in-circuit mode selects the system memory reset vector.
// (R9) Driver bytes arriving on the serial data pin are stored in RAM, then run from RAM.
// (R10) The flash control/status register sits at 0x2f, is read/write and resets to zero.
// (R11) The EEPROM control/status register sits at 0x30, is read/write and resets to zero.
// (R12) Reset release without a valid entry sequence starts from the application vector.
module fpmc_top #(
  parameter int LAT_BYTES = `FPMC_LAT_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic [1:0] opt_s0_size,
  input wire logic rst_pin_n,
  input wire logic prog_serial_clock_pin,
  input wire logic prog_serial_data_pin,
  input wire logic socket_strap,
  output logic arr_wr,
  output logic arr_erase,
  output fpmc_pkg::fpmc_area_t arr_area,
  output logic [15:0] arr_addr,
  output logic [7:0] arr_wdata,
  output logic [15:0] arr_lo,
  output logic [15:0] arr_hi,
  output logic [15:0] boot_vector,
  output logic boot_go,
  output logic ram_wr,
  output logic [15:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_exec
);
  localparam int LW = $clog2(LAT_BYTES);
  localparam logic [9:0] PROG_CYC = 10'(`FPMC_PROG_HOLD_CYC);
  localparam logic [9:0] ERASE_CYC = 10'(`FPMC_ERASE_HOLD_CYC);

  if (LAT_BYTES < 2 || LAT_BYTES > 32 || (1 << LW) != LAT_BYTES) begin : g_bad
    $error("latch count must be a power of two from 2 to 32");
  end

  fpmc_if lk();

  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic sclk_d_q;
  fpmc_pkg::fpmc_mode_t mode_q;
  fpmc_pkg::fpmc_state_t st_q;
  fpmc_pkg::fpmc_area_t area_q;
  fpmc_pkg::fpmc_area_t wa;
  fpmc_pkg::fpmc_area_t er_area;
  logic [2:0] flash_program_control_status_q;
  logic [1:0] eeprom_program_control_status_q;
  logic [1:0] lat_prev_q;
  logic [1:0] s0_sel_q;
  logic s0_loaded_q;
  logic deny_q;
  logic own_ee_q;
  logic [LW-1:0] idx_q;
  logic [9:0] hold_q;
  logic [15-LW:0] row_q;
  logic [7:0] lat_q [LAT_BYTES];
  logic mask_q [LAT_BYTES];
  logic start_fl;
  logic start_ee;
  logic start;
  logic ok;
  logic er_req;
  logic er_ok;
  logic go_erase;
  logic finish;
  logic fl_fin;
  logic ee_fin;
  logic lat_we;
  logic lat_clr;

  // Sector 0 size from the option byte setting
  function automatic logic [15:0] s0_size(input logic [1:0] sel);
    s0_size = 16'(`FPMC_S0_UNIT << sel);
  endfunction

  // Area decode of a CPU write address
  function automatic fpmc_pkg::fpmc_area_t area_of(input logic [15:0] a, input logic opt, input logic [1:0] sel);
    if (a >= `FPMC_EE_BASE && a <= `FPMC_EE_TOP) begin
      area_of = fpmc_pkg::AREA_EE;
    end else if (a >= `FPMC_FLASH_BASE) begin
      if (opt) begin
        area_of = fpmc_pkg::AREA_OPT;
      end else if ((a - `FPMC_FLASH_BASE) < s0_size(sel)) begin
        area_of = fpmc_pkg::AREA_SEC0;
      end else begin
        area_of = fpmc_pkg::AREA_SEC1;
      end
    end else begin
      area_of = fpmc_pkg::AREA_NONE;
    end
  endfunction

  // Which areas each mode may alter
  function automatic logic allowed(input fpmc_pkg::fpmc_area_t ar, input fpmc_pkg::fpmc_mode_t md);
    if (md == fpmc_pkg::MODE_APP) begin
      allowed = ar == fpmc_pkg::AREA_SEC1 || ar == fpmc_pkg::AREA_EE; // [R5]
    end else begin
      allowed = ar != fpmc_pkg::AREA_NONE; // [R3] [R4]
    end
  endfunction

  // Address span of one erasable area, low word then high word
  function automatic logic [31:0] span(input fpmc_pkg::fpmc_area_t ar, input logic [1:0] sel);
    logic [15:0] b;
    b = `FPMC_FLASH_BASE + s0_size(sel);
    unique case (ar)
      fpmc_pkg::AREA_SEC0: span = {`FPMC_FLASH_BASE, b - 16'h0001};
      fpmc_pkg::AREA_SEC1: span = {b, `FPMC_FLASH_TOP};
      fpmc_pkg::AREA_OPT: span = {`FPMC_OPT_LO, `FPMC_OPT_HI};
      default: span = {`FPMC_EE_BASE, `FPMC_EE_TOP};
    endcase
  endfunction

  // Two-stage synchronisers: {strap, data, clock, reset pin}
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 4'h7;
      sync2_q <= 4'h7;
      sclk_d_q <= 1'b1;
    end else begin
      sync1_q <= {socket_strap, prog_serial_data_pin, prog_serial_clock_pin, rst_pin_n};
      sync2_q <= sync1_q;
      sclk_d_q <= sync2_q[1];
    end
  end

  assign lk.sclk_rise = sync2_q[1] && !sclk_d_q;
  assign lk.sdata = sync2_q[2];
  assign lk.rst_low = !sync2_q[0];
  assign lk.rx_en = mode_q == fpmc_pkg::MODE_ICC;

  fpmc_entry #(
    .PULSES(`FPMC_ENTRY_PULSES)
  ) u_entry (
    .clk(clk),
    .rst(rst),
    .lk(lk)
  );

  fpmc_rx u_rx (
    .clk(clk),
    .rst(rst),
    .lk(lk)
  );

  // Driver download goes straight to the RAM port
  assign ram_wr = lk.ram_wr;
  assign ram_addr = lk.ram_addr;
  assign ram_wdata = lk.ram_wdata;
  assign ram_exec = lk.drv_done; // [R9]

  // Mode: socket strap overrides, else the entry decision
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= fpmc_pkg::MODE_APP;
    end else if (sync2_q[3]) begin
      mode_q <= fpmc_pkg::MODE_SOCKET;
    end else if (lk.enter_icc) begin
      mode_q <= fpmc_pkg::MODE_ICC;
    end else if (lk.enter_app || mode_q == fpmc_pkg::MODE_SOCKET) begin
      mode_q <= fpmc_pkg::MODE_APP; // [R12]
    end
  end

  // Reset vector chosen at each reset pin release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_vector <= `FPMC_APP_VECTOR;
      boot_go <= 1'b0;
    end else begin
      boot_go <= lk.enter_icc || lk.enter_app;
      if (lk.enter_icc) begin
        boot_vector <= `FPMC_SYS_VECTOR; // [R8]
      end else if (lk.enter_app) begin
        boot_vector <= `FPMC_APP_VECTOR; // [R12]
      end
    end
  end

  // Option setting caught after reset, never under it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s0_sel_q <= 2'h0;
      s0_loaded_q <= 1'b0;
    end else if (!s0_loaded_q || lk.enter_icc || lk.enter_app) begin
      s0_sel_q <= opt_s0_size; // [R6]
      s0_loaded_q <= 1'b1;
    end
  end

  // Request decode; flash request wins over EEPROM
  assign start_fl = st_q == fpmc_pkg::ST_IDLE && flash_program_control_status_q[`FPMC_BIT_PGM] && flash_program_control_status_q[`FPMC_BIT_LAT];
  assign start_ee = st_q == fpmc_pkg::ST_IDLE && !start_fl && eeprom_program_control_status_q[`FPMC_BIT_PGM] && eeprom_program_control_status_q[`FPMC_BIT_LAT];
  assign start = start_fl || start_ee;
  assign ok = allowed(area_q, mode_q) && ((area_q == fpmc_pkg::AREA_EE) == start_ee);
  assign er_area = fpmc_pkg::fpmc_area_t'({1'b0, reg_wdata[2:1]} + 3'h1);
  assign er_req = reg_wr && reg_addr == `FPMC_OFS_ERASE && reg_wdata[`FPMC_BIT_ERASE_GO]
                  && st_q == fpmc_pkg::ST_IDLE && !(start && ok);
  assign er_ok = allowed(er_area, mode_q);
  assign go_erase = er_req && er_ok;
  assign finish = st_q == fpmc_pkg::ST_HOLD && hold_q == 10'h000;
  assign fl_fin = (finish && !own_ee_q) || (start_fl && !ok);
  assign ee_fin = (finish && own_ee_q) || (start_ee && !ok);

  // Programming sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= fpmc_pkg::ST_IDLE;
      idx_q <= '0;
      hold_q <= 10'h000;
      own_ee_q <= 1'b0;
    end else begin
      unique case (st_q)
        fpmc_pkg::ST_IDLE: begin
          own_ee_q <= start_ee;
          idx_q <= '0;
          if (start && ok) begin
            st_q <= fpmc_pkg::ST_PROG;
          end else if (go_erase) begin
            st_q <= fpmc_pkg::ST_ERASE;
          end
        end
        fpmc_pkg::ST_PROG: begin
          idx_q <= idx_q + 1'b1;
          if (idx_q == LW'(LAT_BYTES - 1)) begin
            st_q <= fpmc_pkg::ST_HOLD; // [R1]
            hold_q <= PROG_CYC;
          end
        end
        fpmc_pkg::ST_ERASE: begin
          st_q <= fpmc_pkg::ST_HOLD;
          hold_q <= ERASE_CYC;
        end
        fpmc_pkg::ST_HOLD: begin
          if (hold_q == 10'h000) begin
            st_q <= fpmc_pkg::ST_IDLE;
          end else begin
            hold_q <= hold_q - 10'h001;
          end
        end
      endcase
    end
  end

  // Flash control/status; writes ignored while busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_program_control_status_q <= 3'(`FPMC_CS_RESET); // [R10]
    end else if (fl_fin) begin
      flash_program_control_status_q[`FPMC_BIT_PGM] <= 1'b0;
      flash_program_control_status_q[`FPMC_BIT_LAT] <= 1'b0;
    end else if (reg_wr && reg_addr == `FPMC_OFS_FLASH_CS && st_q == fpmc_pkg::ST_IDLE) begin
      flash_program_control_status_q <= reg_wdata[2:0]; // [R10]
    end
  end

  // EEPROM control/status; writes ignored while busy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eeprom_program_control_status_q <= 2'(`FPMC_CS_RESET); // [R11]
    end else if (ee_fin) begin
      eeprom_program_control_status_q <= 2'h0;
    end else if (reg_wr && reg_addr == `FPMC_OFS_EE_CS && st_q == fpmc_pkg::ST_IDLE) begin
      eeprom_program_control_status_q <= reg_wdata[1:0]; // [R11]
    end
  end

  // Refused request flag, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deny_q <= 1'b0;
    end else if ((start && !ok) || (er_req && !er_ok)) begin
      deny_q <= 1'b1; // [R5]
    end else if (reg_wr && reg_addr == `FPMC_OFS_STATUS && reg_wdata[`FPMC_BIT_DENY]) begin
      deny_q <= 1'b0;
    end
  end

  // Latch capture: row taken from the last write
  assign wa = area_of(mem_addr, flash_program_control_status_q[`FPMC_BIT_OPT], s0_sel_q);
  assign lat_we = mem_wr && st_q == fpmc_pkg::ST_IDLE
                  && ((wa == fpmc_pkg::AREA_EE && eeprom_program_control_status_q[`FPMC_BIT_LAT])
                  || (wa != fpmc_pkg::AREA_EE && wa != fpmc_pkg::AREA_NONE && flash_program_control_status_q[`FPMC_BIT_LAT]));
  assign lat_clr = finish || |(lat_prev_q & ~{eeprom_program_control_status_q[`FPMC_BIT_LAT], flash_program_control_status_q[`FPMC_BIT_LAT]});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row_q <= '0;
      area_q <= fpmc_pkg::AREA_NONE;
      lat_prev_q <= 2'h0;
    end else begin
      lat_prev_q <= {eeprom_program_control_status_q[`FPMC_BIT_LAT], flash_program_control_status_q[`FPMC_BIT_LAT]};
      if (lat_we) begin
        row_q <= mem_addr[15:LW]; // [R1]
        area_q <= wa; // [R2]
      end
    end
  end

  // Data latches; rewriting a byte ANDs like the cells do
  for (genvar i = 0; i < LAT_BYTES; i++) begin : g_lat
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        lat_q[i] <= 8'hff;
        mask_q[i] <= 1'b0;
      end else if (lat_clr) begin
        lat_q[i] <= 8'hff;
        mask_q[i] <= 1'b0;
      end else if (lat_we && mem_addr[LW-1:0] == LW'(i)) begin
        lat_q[i] <= lat_q[i] & mem_wdata; // [R1]
        mask_q[i] <= 1'b1;
      end
    end
  end

  // Array port: only latched bytes of one row, erase bounded to one area
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arr_wr <= 1'b0;
      arr_erase <= 1'b0;
      arr_area <= fpmc_pkg::AREA_NONE;
      arr_addr <= 16'h0000;
      arr_wdata <= 8'h00;
      arr_lo <= 16'h0000;
      arr_hi <= 16'h0000;
    end else begin
      arr_wr <= st_q == fpmc_pkg::ST_PROG && mask_q[idx_q]; // [R1]
      arr_erase <= go_erase;
      if (st_q == fpmc_pkg::ST_PROG) begin
        arr_addr <= {row_q, idx_q}; // [R2]
        arr_wdata <= lat_q[idx_q];
        arr_area <= area_q;
      end else if (go_erase) begin
        {arr_lo, arr_hi} <= span(er_area, s0_sel_q); // [R2] [R6]
        arr_area <= er_area;
      end
    end
  end

  // Register read port, data valid one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `FPMC_OFS_FLASH_CS: reg_rdata <= {5'h00, flash_program_control_status_q}; // [R10]
        `FPMC_OFS_EE_CS: reg_rdata <= {6'h00, eeprom_program_control_status_q}; // [R11]
        `FPMC_OFS_STATUS: reg_rdata <= {1'b0, lk.drv_done, s0_sel_q, mode_q, deny_q,
                                         st_q != fpmc_pkg::ST_IDLE};
        `FPMC_OFS_RXCNT: reg_rdata <= lk.rx_count;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_PROG_LEN: assert property ($rose(st_q == fpmc_pkg::ST_PROG) |-> ##32 st_q == fpmc_pkg::ST_HOLD)
    else $error("program cycle not 32 slots"); // [R1]
  AST_ROW_FIXED: assert property (arr_wr |-> arr_addr[15:LW] == row_q && $past(st_q) == fpmc_pkg::ST_PROG)
    else $error("write outside latched row"); // [R1]
  AST_SEC1_SPAN: assert property (arr_erase && arr_area == fpmc_pkg::AREA_SEC1
    |-> arr_lo == `FPMC_FLASH_BASE + s0_size(s0_sel_q) && arr_hi == `FPMC_FLASH_TOP)
    else $error("sector 1 erase span wrong"); // [R2] [R6]
  AST_SOCKET_ALL: assert property (er_req && mode_q == fpmc_pkg::MODE_SOCKET
    |=> st_q == fpmc_pkg::ST_ERASE) else $error("socket erase refused"); // [R3]
  AST_ICC_SEC0: assert property (start_fl && area_q == fpmc_pkg::AREA_SEC0 && mode_q == fpmc_pkg::MODE_ICC
    |=> st_q == fpmc_pkg::ST_PROG) else $error("in-circuit sector 0 refused"); // [R4]
  AST_APP_GUARD: assert property ((arr_wr || arr_erase) && $past(mode_q) == fpmc_pkg::MODE_APP
    |-> arr_area == fpmc_pkg::AREA_SEC1 || arr_area == fpmc_pkg::AREA_EE)
    else $error("protected area altered"); // [R5]
  AST_S0_LOAD: assert property ($rose(s0_loaded_q) |-> s0_sel_q == $past(opt_s0_size))
    else $error("sector 0 size not taken"); // [R6]
  AST_ICC_VECTOR: assert property (lk.enter_icc |=> boot_vector == `FPMC_SYS_VECTOR && boot_go
    && mode_q != fpmc_pkg::MODE_APP) else $error("system vector not fetched"); // [R8]
  AST_FLASH_PROGRAM_CONTROL_STATUS_READ: assert property (reg_rd && reg_addr == `FPMC_OFS_FLASH_CS
    |=> reg_rdata == {5'h00, $past(flash_program_control_status_q)}) else $error("flash status read wrong"); // [R10]
  AST_EEPROM_PROGRAM_CONTROL_STATUS_READ: assert property (reg_rd && reg_addr == `FPMC_OFS_EE_CS
    |=> reg_rdata == {6'h00, $past(eeprom_program_control_status_q)}) else $error("EEPROM status read wrong"); // [R11]
  AST_APP_VECTOR: assert property (lk.enter_app |=> boot_vector == `FPMC_APP_VECTOR && boot_go)
    else $error("application vector not taken"); // [R12]

  COV_PROG_DONE: cover property (st_q == fpmc_pkg::ST_HOLD ##1 st_q == fpmc_pkg::ST_IDLE && !own_ee_q);
  COV_ICC_ENTRY: cover property (lk.enter_icc);
  COV_DENIED: cover property ($rose(deny_q));
endmodule

// >>> fpmc_tool.sv
`timescale 1ns/1ns
// External programming tool on the serial cable
module fpmc_tool (
  output logic rst_pin_n,
  output logic sclk,
  output logic sdata
);
  // Clock line is pulled up and stands high outside frames
  initial begin
    rst_pin_n = 1'b1;
    sclk = 1'b1;
    sdata = 1'b0;
  end
  // One pulse; data set while the clock is low, taken at the rise
  task automatic pulse(input logic b);
    sclk = 1'b0;
    sdata = b;
    #62;
    sclk = 1'b1;
    #63;
  endtask
  // Entry pulses only while the reset pin is held low
  task automatic enter(input int n);
    rst_pin_n = 1'b0;
    #500;
    for (int i = 0; i < n; i++) pulse(i[0]);
    #500;
    rst_pin_n = 1'b1;
    sdata = ~sdata; // Released line shows no stale level
  endtask
  // Driver code, byte by byte, high bit first
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) pulse(b[i]);
    sdata = ~sdata;
  endtask
endmodule

// >>> fpmc_top_test.sv
`timescale 1ns/1ns
module fpmc_top_test;
  logic clk, rst, reg_wr, reg_rd, mem_wr, socket_strap, rd_d;
  logic rst_pin_n, sclk, sdata, arr_wr, arr_erase, boot_go, ram_wr, ram_exec;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mem_wdata, ram_wdata, arr_wdata, rd_val, d;
  logic [15:0] mem_addr, arr_addr, arr_lo, arr_hi, boot_vector, ram_addr, s0;
  logic [1:0] opt_s0_size;
  fpmc_pkg::fpmc_area_t arr_area;
  logic [8:0] rd_q[$];
  logic [39:0] ev_q[$];
  int num_errors, n_compared, cycles;
  fpmc_top #(.LAT_BYTES(32)) dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .opt_s0_size(opt_s0_size), .rst_pin_n(rst_pin_n), .prog_serial_clock_pin(sclk),
    .prog_serial_data_pin(sdata), .socket_strap(socket_strap), .arr_wr(arr_wr), .arr_erase(arr_erase),
    .arr_area(arr_area), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_lo(arr_lo), .arr_hi(arr_hi),
    .boot_vector(boot_vector), .boot_go(boot_go), .ram_wr(ram_wr), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_exec(ram_exec));
  fpmc_tool tool_u (.rst_pin_n(rst_pin_n), .sclk(sclk), .sdata(sdata));
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (ev_q.size() != 0 || rd_q.size() != 0) num_errors++; // Results that never came
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      test_done();
    end
  end
  // Watcher: each result seen is matched against the oldest note
  always @(posedge clk) begin
    logic [39:0] seen;
    logic [8:0] e;
    rd_d <= reg_rd;
    seen = '0;
    if (rd_d) begin
      rd_val = reg_rdata;
      e = rd_q.pop_front();
      if (e[8]) check("reg_rdata", {32'h0, reg_rdata}, {32'h0, e[7:0]});
    end
    if (arr_wr) seen = {4'h1, 1'b0, arr_area, arr_addr, 8'h00, arr_wdata};
    if (arr_erase) seen = {4'h2, 1'b0, arr_area, arr_lo, arr_hi};
    if (boot_go) seen = {4'h3, 4'h0, boot_vector, 16'h0000};
    if (ram_wr) seen = {4'h4, 4'h0, ram_addr, 8'h00, ram_wdata};
    if (seen[39:36] != 4'h0) check("event", seen, ev_q.pop_front());
  end
  // Register bus; one spare cycle after each strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic chk);
    rd_q.push_back({chk, exp});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic mw(input logic [15:0] a, input logic [7:0] v);
    mem_addr <= a;
    mem_wdata <= v;
    mem_wr <= 1'b1;
    @(posedge clk);
    mem_wr <= 1'b0;
    @(posedge clk);
  endtask
  // Poll the busy flag under a bound
  task automatic idle();
    repeat (4) @(posedge clk);
    for (int i = 0; i < 300; i++) begin
      rd(8'h3d, 8'h00, 1'b0);
      #1;
      if (rd_val[0] === 1'b0) break;
    end
    if (rd_val[0] !== 1'b0) num_errors++; // Busy never cleared
  endtask
  // Erase request; a refused one must leave no pulse
  task automatic er(input logic [7:0] c, input logic [3:0] ar, input logic [15:0] lo, input logic [15:0] hi,
                    input logic ok);
    if (ok) ev_q.push_back({4'h2, ar, lo, hi});
    wr(8'h3f, c);
    idle();
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, mem_wr, socket_strap, mem_addr, mem_wdata} = '0;
    d = 8'($urandom(32'h8de6));
    opt_s0_size = 2'($urandom % 4);
    d = 8'($urandom);
    s0 = 16'h0100 << opt_s0_size;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h2f, 8'h00, 1'b1);
    rd(8'h30, 8'h00, 1'b1);
    wr(8'h30, 8'h02);
    rd(8'h30, 8'h02, 1'b1);
    wr(8'h30, 8'h00);
    wr(8'h2f, 8'h04);
    rd(8'h2f, 8'h04, 1'b1);
    wr(8'h2f, 8'h00);
    rd(8'h31, 8'h00, 1'b1);
    rd(8'h3d, {2'b00, opt_s0_size, 4'h0}, 1'b1);
    // Several latched bytes, one overwritten, programmed in one go in sector 1
    wr(8'h2f, 8'h02);
    mw(16'hffe5, 8'h5f);
    mw(16'hffe2, d);
    mw(16'hffe5, 8'h3a);
    ev_q.push_back({4'h1, 4'd2, 16'hffe2, 8'h00, d});
    ev_q.push_back({4'h1, 4'd2, 16'hffe5, 8'h00, 8'h1a});
    wr(8'h2f, 8'h03);
    idle();
    rd(8'h2f, 8'h00, 1'b1);
    // One EEPROM byte through the latches shared with flash
    wr(8'h30, 8'h02);
    mw(16'h1003, d);
    ev_q.push_back({4'h1, 4'd4, 16'h1003, 8'h00, d});
    wr(8'h30, 8'h03);
    idle();
    rd(8'h30, 8'h00, 1'b1);
    // Sector 0 is out of reach while the application runs
    wr(8'h2f, 8'h02);
    mw(16'hf005, d);
    wr(8'h2f, 8'h03);
    idle();
    rd(8'h3d, {2'b00, opt_s0_size, 4'h2}, 1'b1);
    er(8'h03, 4'd2, 16'hf000 + s0, 16'hffff, 1'b1);
    er(8'h01, 4'd1, 16'h0, 16'h0, 1'b0);
    er(8'h05, 4'd3, 16'h0, 16'h0, 1'b0);
    er(8'h07, 4'd4, 16'h1000, 16'h107f, 1'b1);
    wr(8'h3d, 8'h02);
    // Programming socket opens sector 0 and the option row
    socket_strap <= 1'b1;
    repeat (6) @(posedge clk);
    rd(8'h3d, {2'b00, opt_s0_size, 4'h8}, 1'b1);
    er(8'h01, 4'd1, 16'hf000, 16'hf000 + s0 - 16'h1, 1'b1);
    er(8'h05, 4'd3, 16'h0000, 16'h001f, 1'b1);
    socket_strap <= 1'b0;
    // Entry under held reset, then a two-byte driver download
    ev_q.push_back({4'h3, 4'h0, 16'hbffe, 16'h0000});
    tool_u.enter(35);
    repeat (20) @(posedge clk);
    rd(8'h3d, {2'b00, opt_s0_size, 4'h4}, 1'b1);
    ev_q.push_back({4'h4, 4'h0, 16'h0080, 8'h00, d});
    ev_q.push_back({4'h4, 4'h0, 16'h0081, 8'h00, ~d});
    tool_u.send(8'h02);
    tool_u.send(d);
    tool_u.send(~d);
    repeat (10) @(posedge clk);
    check("ram_exec", {39'h0, ram_exec}, 40'h1);
    er(8'h01, 4'd1, 16'hf000, 16'hf000 + s0 - 16'h1, 1'b1);
    rd(8'h3e, 8'h02, 1'b1);
    wr(8'h2f, 8'h02);
    mw(16'hf005, ~d);
    ev_q.push_back({4'h1, 4'd1, 16'hf005, 8'h00, ~d});
    wr(8'h2f, 8'h03);
    idle();
    // Too few pulses: normal start
    ev_q.push_back({4'h3, 4'h0, 16'hfffe, 16'h0000});
    tool_u.enter(34);
    repeat (20) @(posedge clk);
    check("ram_exec", {39'h0, ram_exec}, 40'h0);
    rd(8'h3d, {2'b00, opt_s0_size, 4'h0}, 1'b1);
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
